// ===== hdl/tap_port.sv
// Boundary-scan test access port controller with its serial registers.
`timescale 1ns/10ps
`default_nettype none
`include "tap_map.svh"
module tap_port (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output var  logic tdo_o,
  output var  logic tdo_oe_n_o,
  output var  logic tms_pu_o,
  output var  logic tdi_pu_o,
  output var  logic hiz_o,
  output var  logic test_reset_o
);

  tap_pkg::tap_state_t     state;
  tap_pkg::tap_state_t     next_state;
  logic [2:0]              rst_sync;
  logic                    tck_rst;
  logic [`IR_W-1:0]        ir;
  logic [`IR_W-1:0]        ir_shift;
  logic [`IR_W-1:0]        next_ir;
  logic [`ID_W-1:0]        id_shift;
  logic                    bypass;
  logic                    shifting;
  logic                    next_tdo;
  tap_pkg::tap_flags_t     flags;
  tap_pkg::tap_flags_t     flags_s1;
  tap_pkg::tap_flags_t     flags_s2;
  tap_pkg::tap_flags_t     flags_s3;

  // Instructions without a register here fall back to the one-bit path.
  function automatic logic sel_id(input logic [`IR_W-1:0] ins);
    sel_id = (ins == `INS_IDCODE);
  endfunction

  // Power-up reset reaches the test clock domain through three stages.
  // It takes effect only while TCK runs, so the board must toggle TCK.
  always_ff @(posedge tck_i)
  begin
    rst_sync <= {rst_sync[1:0], rstn_i};
  end

  always_ff @(posedge tck_i)
  begin
    if (rst_sync[1] == rst_sync[2])
    begin
      tck_rst <= !rst_sync[2];
    end
  end

  // Controller transitions, steered only by TMS at rising TCK.
  always_comb
  begin
    next_state = state;
    case (state)
      tap_pkg::TLR:    next_state = tms_i ? tap_pkg::TLR    : tap_pkg::RTI;
      tap_pkg::RTI:    next_state = tms_i ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: next_state = tms_i ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: next_state = tms_i ? tap_pkg::EX1_DR : tap_pkg::SHF_DR;
      tap_pkg::SHF_DR: next_state = tms_i ? tap_pkg::EX1_DR : tap_pkg::SHF_DR;
      tap_pkg::EX1_DR: next_state = tms_i ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
      tap_pkg::PAU_DR: next_state = tms_i ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
      tap_pkg::EX2_DR: next_state = tms_i ? tap_pkg::UPD_DR : tap_pkg::SHF_DR;
      tap_pkg::UPD_DR: next_state = tms_i ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: next_state = tms_i ? tap_pkg::TLR    : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: next_state = tms_i ? tap_pkg::EX1_IR : tap_pkg::SHF_IR;
      tap_pkg::SHF_IR: next_state = tms_i ? tap_pkg::EX1_IR : tap_pkg::SHF_IR;
      tap_pkg::EX1_IR: next_state = tms_i ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
      tap_pkg::PAU_IR: next_state = tms_i ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
      tap_pkg::EX2_IR: next_state = tms_i ? tap_pkg::UPD_IR : tap_pkg::SHF_IR;
      tap_pkg::UPD_IR: next_state = tms_i ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default:         next_state = tap_pkg::TLR;
    endcase
  end

  always_ff @(posedge tck_i)
  begin
    if (tck_rst)
    begin
      state <= tap_pkg::TLR;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Instruction shift stage and the held instruction.
  always_ff @(posedge tck_i)
  begin
    if (tck_rst)
    begin
      ir_shift <= `INS_IDCODE;
    end
    else if (state == tap_pkg::CAP_IR)
    begin
      ir_shift <= {`IR_CAP_HIGH, `IR_CAP_LOW};
    end
    else if (state == tap_pkg::SHF_IR)
    begin
      ir_shift <= {tdi_i, ir_shift[`IR_W-1:1]};
    end
  end

  always_ff @(posedge tck_i)
  begin
    if (tck_rst || state == tap_pkg::TLR)
    begin
      ir <= `INS_IDCODE;
    end
    else if (state == tap_pkg::UPD_IR)
    begin
      ir <= ir_shift;
    end
  end

  // Instruction that the held register takes at the coming rising edge.
  always_comb
  begin
    next_ir = ir;
    if (state == tap_pkg::TLR)
    begin
      next_ir = `INS_IDCODE;
    end
    else if (state == tap_pkg::UPD_IR)
    begin
      next_ir = ir_shift;
    end
  end

  // Data registers: identification word and the one-bit bypass.
  always_ff @(posedge tck_i)
  begin
    if (tck_rst)
    begin
      id_shift <= `ID_VALUE;
    end
    else if (state == tap_pkg::CAP_DR && sel_id(ir))
    begin
      id_shift <= `ID_VALUE;
    end
    else if (state == tap_pkg::SHF_DR && sel_id(ir))
    begin
      id_shift <= {tdi_i, id_shift[`ID_W-1:1]};
    end
  end

  always_ff @(posedge tck_i)
  begin
    if (tck_rst)
    begin
      bypass <= `BYPASS_CAP;
    end
    else if (state == tap_pkg::CAP_DR && !sel_id(ir))
    begin
      bypass <= `BYPASS_CAP;
    end
    else if (state == tap_pkg::SHF_DR && !sel_id(ir))
    begin
      bypass <= tdi_i;
    end
  end

  // Serial output choice; the low bit leaves first.
  always_comb
  begin
    shifting = (state == tap_pkg::SHF_DR) || (state == tap_pkg::SHF_IR);
    if (state == tap_pkg::SHF_IR)
    begin
      next_tdo = ir_shift[0];
    end
    else if (sel_id(ir))
    begin
      next_tdo = id_shift[0];
    end
    else
    begin
      next_tdo = bypass;
    end
  end

  // Output pin updates on falling TCK so the far end samples a settled bit.
  always_ff @(negedge tck_i)
  begin
    if (tck_rst)
    begin
      tdo_o      <= 1'h0;
      tdo_oe_n_o <= 1'h1;
    end
    else
    begin
      tdo_o      <= next_tdo;
      tdo_oe_n_o <= !shifting;
    end
  end

  // Pad pull-up enables; a disabled port then reads TMS high and stays reset.
  always_ff @(posedge clk_i)
  begin
    tms_pu_o <= 1'h1;
    tdi_pu_o <= 1'h1;
  end

  // Flags toward the memory clock domain.
  // They follow the coming state and instruction, so they settle even if TCK then stops.
  always_ff @(posedge tck_i)
  begin
    if (tck_rst)
    begin
      flags <= '{hiz: 1'h0, test_reset: 1'h1};
    end
    else
    begin
      flags.hiz        <= (next_ir == `INS_EXTEST) || (next_ir == `INS_SAMPLEZ);
      flags.test_reset <= (next_state == tap_pkg::TLR);
    end
  end

  always_ff @(posedge clk_i)
  begin
    flags_s1 <= flags;
    flags_s2 <= flags_s1;
    flags_s3 <= flags_s2;
  end

  // A flag is accepted only once two late stages agree, filtering glitches.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      hiz_o        <= 1'h0;
      test_reset_o <= 1'h1;
    end
    else
    begin
      if (flags_s2.hiz == flags_s3.hiz)
      begin
        hiz_o <= flags_s3.hiz;
      end
      if (flags_s2.test_reset == flags_s3.test_reset)
      begin
        test_reset_o <= flags_s3.test_reset;
      end
    end
  end

  sequence s_tms_high5;
    tms_i [*5];
  endsequence

  sequence s_capture_ir;
    state == tap_pkg::CAP_IR;
  endsequence

  property p_tms_reset;
    @(posedge tck_i) disable iff (tck_rst)
    s_tms_high5 |=> (state == tap_pkg::TLR);
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("Five TMS highs did not reach reset.");

  property p_reset_loads_id;
    @(posedge tck_i) disable iff (tck_rst)
    (state == tap_pkg::TLR) |=> (ir == `INS_IDCODE);
  endproperty
  a_reset_loads_id: assert property (p_reset_loads_id)
    else $error("Reset state did not load identification.");

  property p_cap_ir;
    @(posedge tck_i) disable iff (tck_rst)
    s_capture_ir |=> (ir_shift[1:0] == `IR_CAP_LOW);
  endproperty
  a_cap_ir: assert property (p_cap_ir)
    else $error("Instruction capture did not load 01.");

  property p_ir_held;
    @(posedge tck_i) disable iff (tck_rst)
    (state == tap_pkg::SHF_IR) |=> $stable(ir);
  endproperty
  a_ir_held: assert property (p_ir_held)
    else $error("Instruction changed during shift.");

  property p_ir_update;
    @(posedge tck_i) disable iff (tck_rst)
    (state == tap_pkg::UPD_IR) |=> (ir == $past(ir_shift));
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("Update did not load shifted instruction.");

  property p_msb_in;
    @(posedge tck_i) disable iff (tck_rst)
    (state == tap_pkg::SHF_IR) |=> (ir_shift[`IR_W-1] == $past(tdi_i));
  endproperty
  a_msb_in: assert property (p_msb_in)
    else $error("TDI did not enter top bit.");

  property p_oe_shift;
    @(posedge tck_i) disable iff (tck_rst)
    !tck_rst |=> (tdo_oe_n_o == !shifting);
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("TDO enable does not match shift state.");

  property p_tdo_lsb;
    @(posedge tck_i) disable iff (tck_rst)
    (state == tap_pkg::SHF_IR) ##1 (state == tap_pkg::SHF_IR)
      |-> (tdo_o == ir_shift[0]);
  endproperty
  a_tdo_lsb: assert property (p_tdo_lsb)
    else $error("TDO is not the low instruction bit.");

  property p_bypass_path;
    @(posedge tck_i) disable iff (tck_rst)
    (state == tap_pkg::SHF_DR && !sel_id(ir)) ##1 (state == tap_pkg::SHF_DR)
      |-> (tdo_o == bypass);
  endproperty
  a_bypass_path: assert property (p_bypass_path)
    else $error("Selected path is not bypass.");

  property p_pullups;
    @(posedge clk_i) disable iff (!rstn_i)
    ##1 (tms_pu_o && tdi_pu_o);
  endproperty
  a_pullups: assert property (p_pullups)
    else $error("Pull-up enable dropped.");

endmodule
`default_nettype wire

// ===== common/tap_map.svh
// Constants for the boundary-scan test access port.
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define IR_W         3
`define ID_W         32
`define IR_CAP_LOW   2'h1
`define IR_CAP_HIGH  1'h0
`define INS_EXTEST   3'h0
`define INS_IDCODE   3'h1
`define INS_SAMPLEZ  3'h2
`define INS_SAMPLE   3'h4
`define INS_BYPASS   3'h7
`define ID_VALUE     32'h0000_0001
`define BYPASS_CAP   1'h0
`define RESET_TMS    5
`endif

// ===== common/tap_pkg.sv
// Types for the boundary-scan test access port.
`default_nettype none
package tap_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;
  typedef struct packed {
    logic hiz;
    logic test_reset;
  } tap_flags_t;
endpackage
`default_nettype wire

// ===== tb/scan_ctrl.sv
// Board-level scan controller model that drives the test clock and pins.
`timescale 1ns/10ps
`default_nettype none
module scan_ctrl (
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  output var  logic float_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i
);
  initial
  begin
    tck_o   = 1'b0;
    tms_o   = 1'b1;
    tdi_o   = 1'b1;
    float_o = 1'b0;
  end

  // Pins change only while the clock is low, half a period before the rising edge.
  // The clock stands low between calls, so the port sees no edges outside frames.
  task automatic step(input logic m, input logic d, output logic q, output logic oe_n);
    tms_o = m;
    tdi_o = d;
    #15;
    q = tdo_i;
    oe_n = tdo_oe_n_i;
    tck_o = 1'b1;
    #15;
    tck_o = 1'b0;
  endtask

  // The last bit carries a high mode level so the walk leaves the shift state.
  task automatic shift(input int n, input logic [32:0] d, output logic [32:0] q,
                       output logic [32:0] oe);
    q = '0;
    oe = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, d[i], q[i], oe[i]);
    end
  endtask

  // The pins are released and driven low behind the release, so only the pull-ups act.
  task automatic reset5();
    logic q;
    logic oe_n;
    float_o = 1'b1;
    repeat (5) step(1'b0, 1'b0, q, oe_n);
    float_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_tap_port.sv
// Self-checking testbench for the boundary-scan test access port.
`timescale 1ns/10ps
`default_nettype none
`include "tap_map.svh"
module test_tap_port;
  logic        clk_i;
  logic        rstn_i;
  logic        tck;
  logic        tms_d;
  logic        tdi_d;
  logic        flt;
  logic        tdo_o;
  logic        tdo_oe_n_o;
  logic        tms_pu_o;
  logic        tdi_pu_o;
  logic        hiz_o;
  logic        test_reset_o;
  logic        b;
  logic        oe_n;
  logic        tdo_hold;
  logic        oe_hold;
  logic [2:0]  ins;
  logic [15:0] seed;
  int          err_total;
  int          compares;
  wire         tms_i = flt ? tms_pu_o : tms_d;
  wire         tdi_i = flt ? tdi_pu_o : tdi_d;

  tap_port tap_port_inst (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .tms_i(tms_i),
    .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .tms_pu_o(tms_pu_o),
    .tdi_pu_o(tdi_pu_o), .hiz_o(hiz_o), .test_reset_o(test_reset_o));
  scan_ctrl scan_ctrl_inst (.tck_o(tck), .tms_o(tms_d), .tdi_o(tdi_d), .float_o(flt),
    .tdo_i(tdo_o), .tdo_oe_n_i(tdo_oe_n_o));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic logic hiz_exp(input logic [2:0] c);
    return c == `INS_EXTEST || c == `INS_SAMPLEZ;
  endfunction

  // Identification shifts its code first; everything else is the one-bit bypass.
  function automatic logic [32:0] exp_dr(input logic [2:0] c, input logic [31:0] w);
    return c == `INS_IDCODE ? {w[0], `ID_VALUE} : {w, `BYPASS_CAP};
  endfunction

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic read_dr();
    logic [31:0] w;
    logic [32:0] q;
    logic [32:0] oe;
    w = {rnd(), rnd()};
    scan_ctrl_inst.step(1'b1, 1'b0, b, oe_n);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    scan_ctrl_inst.shift(33, {w[0], w}, q, oe);
    check(q, exp_dr(ins, w));
    check(oe, 33'h0);
    scan_ctrl_inst.step(1'b1, 1'b0, b, oe_n);
    check(33'(oe_n), 33'h1);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
  endtask

  task automatic load_ir(input logic [2:0] c);
    logic [32:0] q;
    logic [32:0] oe;
    scan_ctrl_inst.step(1'b1, 1'b0, b, oe_n);
    scan_ctrl_inst.step(1'b1, 1'b0, b, oe_n);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    scan_ctrl_inst.shift(3, 33'(c), q, oe);
    check(33'(q[2:0]), 33'({`IR_CAP_HIGH, `IR_CAP_LOW}));
    repeat (10) @(posedge clk_i);
    check(33'(hiz_o), 33'(hiz_exp(ins)));
    scan_ctrl_inst.step(1'b1, 1'b0, b, oe_n);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    ins = c;
    repeat (10) @(posedge clk_i);
    check(33'({test_reset_o, hiz_o}), 33'({1'b0, hiz_exp(c)}));
  endtask

  // Outputs launched on the falling edge must not move just after a rising edge.
  always @(posedge tck)
  begin
    tdo_hold = tdo_o;
    oe_hold = tdo_oe_n_o;
    #5;
    check(33'({tdo_o, tdo_oe_n_o}), 33'({tdo_hold, oe_hold}));
  end

  initial
  begin
    #300000;
    err_total++;
    summarize();
  end

  initial
  begin
    rstn_i = 1'b0;
    seed = 16'h004A;
    ins = `INS_IDCODE;
    err_total = 0;
    compares = 0;
    fork
      repeat (5) @(posedge clk_i);
      repeat (8) scan_ctrl_inst.step(1'b1, 1'b1, b, oe_n);
    join
    @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) scan_ctrl_inst.step(1'b1, 1'b1, b, oe_n);
    repeat (10) @(posedge clk_i);
    check(33'({test_reset_o, hiz_o, tdo_oe_n_o}), 33'h5);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    read_dr();
    for (int k = 0; k < 8; k++)
    begin
      load_ir(k[2:0]);
      read_dr();
    end
    load_ir(`INS_EXTEST);
    scan_ctrl_inst.reset5();
    ins = `INS_IDCODE;
    repeat (10) @(posedge clk_i);
    check(33'({test_reset_o, hiz_o}), 33'h2);
    scan_ctrl_inst.step(1'b0, 1'b0, b, oe_n);
    read_dr();
    summarize();
  end
endmodule
`default_nettype wire
